// File: srm_regs.svh
/*
  Constants for the stream resource manager: default sizes, operation and
  status codes, report field positions.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

// default sizes
`define SRM_MAX_STREAMS_DEF   8
`define SRM_NS_NUM_DEF        4
`define SRM_STAMP_W_DEF       16
`define SRM_CNT_W             16
`define SRM_SID_W             16

// operation and namespace codes
`define SRM_OP_RETURN_PARAMS  8'h01
`define SRM_NAMESPACE_IDENTIFIER_BROADCAST    32'hffffffff

// completion status codes
`define SRM_STS_OK            8'h00
`define SRM_STS_INVALID_FIELD 8'h02
`define SRM_STS_ALLOC_FAILED  8'h7f

// subsystem report section, bit positions of the byte fields
`define SRM_RPT_MAX_LSB       0
`define SRM_RPT_AVAIL_LSB     16
`define SRM_RPT_OPEN_LSB      32
`define SRM_RPT_RSVD_LSB      48
`define SRM_RPT_W             128

`endif

// File: srm_pkg.sv
/*
  Types shared by the stream resource manager.
  Assumes srm_regs.svh is on the include path.
*/
`include "srm_regs.svh"

package srm_pkg;
  // completion status of a command
  typedef enum logic [7:0] {
    SRM_OK            = `SRM_STS_OK,
    SRM_INVALID_FIELD = `SRM_STS_INVALID_FIELD,
    SRM_ALLOC_FAILED  = `SRM_STS_ALLOC_FAILED
  } srm_status_t;

  typedef logic [`SRM_CNT_W-1:0] srm_cnt_t;
  typedef logic [`SRM_SID_W-1:0] srm_sid_t;
endpackage

// File: srm_stream_manager.sv
/*
  Stream resource manager: table of open write streams, per-namespace
  exclusive allocations, shared pool accounting, eviction and the
  subsystem part of the parameter report.
  Assumes command strobes come from logic on the same clock, at most one
  command kind per cycle (lower priority ones are ignored), single host.
*/
// Behaviour
// - namespace uses exclusive or shared, never both
// - exclusive allocation caps open streams per namespace
// - reallocation only after whole allocation released
// - unknown identifier on write opens a stream
// - exhausted exclusive allocation evicts same-namespace stream
// - exhausted shared pool evicts any shared stream
// - no shared resources means plain unassociated write
// - directive disable releases namespace streams and allocation
// - format or delete releases affected namespace streams
// - no exclusive and no shared gives 7Fh
// - operation 01h returns parameter report
// - directive specific field ignored for report
// - broadcast namespace zeroes namespace specific fields
// - bytes 1:0 maximum open streams, 15:6 reserved
// - bytes 3:2 shared streams still available
// - bytes 5:4 streams open without allocation
// - each grant reduces shared available count
// - allocation answer reports granted count
// - second allocation for namespace gives invalid field
`timescale 1ns/1ps
`default_nettype none
`include "srm_regs.svh"

module srm_stream_manager #(
  parameter int unsigned MAX_STREAMS = `SRM_MAX_STREAMS_DEF,
  parameter int unsigned NS_NUM      = `SRM_NS_NUM_DEF,
  parameter int unsigned STAMP_W     = `SRM_STAMP_W_DEF,
  localparam int unsigned SW         = (MAX_STREAMS > 1) ? $clog2(MAX_STREAMS) : 1,
  localparam int unsigned NSW        = (NS_NUM > 1) ? $clog2(NS_NUM) : 1
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // write command
  input  wire logic                  i_wr_valid,
  input  wire logic [NSW-1:0]        i_wr_ns,
  input  wire srm_pkg::srm_sid_t     i_wr_sid,
  output logic                       o_wr_done,
  output logic                       o_wr_streamed,
  output logic                       o_wr_evicted,
  output logic [SW-1:0]              o_wr_slot,
  // allocate resources
  input  wire logic                  i_alloc_valid,
  input  wire logic [NSW-1:0]        i_alloc_ns,
  input  wire srm_pkg::srm_cnt_t     i_alloc_count,
  output logic                       o_alloc_done,
  output srm_pkg::srm_status_t       o_alloc_status,
  output srm_pkg::srm_cnt_t          o_alloc_granted,
  // release resources, directive disable, format or delete
  input  wire logic                  i_relres_valid,
  input  wire logic [NSW-1:0]        i_relres_ns,
  input  wire logic                  i_disable_valid,
  input  wire logic [NSW-1:0]        i_disable_ns,
  input  wire logic                  i_format_valid,
  input  wire logic [NS_NUM-1:0]     i_format_ns_mask,
  // parameter report
  input  wire logic                  i_rpt_valid,
  input  wire logic [7:0]            i_rpt_op,
  input  wire logic [31:0]           i_rpt_namespace_identifier,
  input  wire srm_pkg::srm_sid_t     i_rpt_directive_specific_field,
  output logic                       o_rpt_done,
  output srm_pkg::srm_status_t       o_rpt_status,
  output logic [`SRM_RPT_W-1:0]      o_rpt_subsys,
  output srm_pkg::srm_cnt_t          o_rpt_ns_streams_allocated,
  output srm_pkg::srm_cnt_t          o_rpt_ns_open
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (MAX_STREAMS < 1 || MAX_STREAMS > 65535 || NS_NUM < 1 || STAMP_W < 2) begin : g_bad
    $error("srm_stream_manager: unsupported parameter values");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  logic [MAX_STREAMS-1:0] ent_vld_q;
  logic [NSW-1:0]         ent_ns_q    [MAX_STREAMS];
  srm_pkg::srm_sid_t      ent_sid_q   [MAX_STREAMS];
  logic [STAMP_W-1:0]     ent_stamp_q [MAX_STREAMS];
  srm_pkg::srm_cnt_t      alloc_q     [NS_NUM];
  logic [STAMP_W-1:0]     stamp_q;

  // one command kind per cycle; format first, report last
  logic cmd_fmt, cmd_dis, cmd_rel, cmd_alloc, cmd_wr, cmd_rpt;
  assign cmd_fmt   = i_format_valid;
  assign cmd_dis   = i_disable_valid & ~cmd_fmt;
  assign cmd_rel   = i_relres_valid & ~cmd_fmt & ~i_disable_valid;
  assign cmd_alloc = i_alloc_valid & ~cmd_fmt & ~i_disable_valid & ~i_relres_valid;
  assign cmd_wr    = i_wr_valid & ~cmd_fmt & ~i_disable_valid & ~i_relres_valid
                     & ~i_alloc_valid;
  assign cmd_rpt   = i_rpt_valid & ~cmd_fmt & ~i_disable_valid & ~i_relres_valid
                     & ~i_alloc_valid & ~i_wr_valid;

  // namespace draws from the shared pool when it holds no allocation
  function automatic logic is_shared(input srm_pkg::srm_cnt_t alloc);
    return alloc == '0;
  endfunction

  // ***************************************************************
  // accounting, derived from the table so it cannot drift
  // ***************************************************************
  srm_pkg::srm_cnt_t sum_alloc, pool_avail, pool_open;
  srm_pkg::srm_cnt_t ns_open [NS_NUM];

  always_comb begin
    sum_alloc = '0;
    pool_open = '0;
    for (int n = 0; n < NS_NUM; n++) begin
      ns_open[n] = '0;
      sum_alloc  = sum_alloc + alloc_q[n];
    end
    for (int e = 0; e < MAX_STREAMS; e++) begin
      if (ent_vld_q[e]) begin
        ns_open[ent_ns_q[e]] = ns_open[ent_ns_q[e]] + 16'h0001;
        if (is_shared(alloc_q[ent_ns_q[e]])) begin
          pool_open = pool_open + 16'h0001;
        end
      end
    end
    pool_avail = 16'(MAX_STREAMS) - sum_alloc;
  end

  // ***************************************************************
  // write lookup: hit, free slot, oldest victims
  // ***************************************************************
  logic                 hit, free_ok, vns_ok, vpool_ok;
  logic [SW-1:0]        hit_idx, free_idx, vns_idx, vpool_idx;
  logic [STAMP_W-1:0]   vns_age, vpool_age;

  always_comb begin
    hit = 1'b0; free_ok = 1'b0; vns_ok = 1'b0; vpool_ok = 1'b0;
    hit_idx = '0; free_idx = '0; vns_idx = '0; vpool_idx = '0;
    vns_age = '0; vpool_age = '0;
    for (int e = 0; e < MAX_STREAMS; e++) begin
      if (!ent_vld_q[e]) begin
        if (!free_ok) begin
          free_ok  = 1'b1;
          free_idx = SW'(e);
        end
      end else begin
        if (ent_ns_q[e] == i_wr_ns && ent_sid_q[e] == i_wr_sid) begin
          hit     = 1'b1;
          hit_idx = SW'(e);
        end
        // age is distance from the running stamp, so wrap is harmless
        if (ent_ns_q[e] == i_wr_ns && (!vns_ok || stamp_q - ent_stamp_q[e] > vns_age)) begin
          vns_ok  = 1'b1;
          vns_idx = SW'(e);
          vns_age = stamp_q - ent_stamp_q[e];
        end
        if (is_shared(alloc_q[ent_ns_q[e]])
            && (!vpool_ok || stamp_q - ent_stamp_q[e] > vpool_age)) begin
          vpool_ok  = 1'b1;
          vpool_idx = SW'(e);
          vpool_age = stamp_q - ent_stamp_q[e];
        end
      end
    end
  end

  // ***************************************************************
  // write decision
  // ***************************************************************
  logic          wr_use, wr_new, wr_evict;
  logic [SW-1:0] wr_slot;
  logic          wr_excl;
  assign wr_excl = !is_shared(alloc_q[i_wr_ns]);

  always_comb begin
    wr_use = 1'b0; wr_new = 1'b0; wr_evict = 1'b0; wr_slot = '0;
    // identifier zero never names a stream
    if (i_wr_sid == '0) begin
      wr_use = 1'b0;
    end else if (hit) begin
      wr_use  = 1'b1;
      wr_slot = hit_idx;
    end else if (wr_excl) begin
      wr_use = 1'b1;
      wr_new = 1'b1;
      if (ns_open[i_wr_ns] < alloc_q[i_wr_ns]) begin
        wr_slot = free_idx;
      end else begin
        wr_slot  = vns_idx;
        wr_evict = 1'b1;
      end
    end else if (pool_avail != '0) begin
      wr_use = 1'b1;
      wr_new = 1'b1;
      if (pool_open < pool_avail && free_ok) begin
        wr_slot = free_idx;
      end else begin
        wr_slot  = vpool_idx;
        wr_evict = 1'b1;
      end
    end
    // otherwise everything is allocated elsewhere: plain write
  end

  // ***************************************************************
  // allocation decision
  // ***************************************************************
  srm_pkg::srm_cnt_t   al_room, al_grant;
  srm_pkg::srm_status_t al_sts;

  always_comb begin
    // room: shared slots not held by other shared namespaces
    al_room  = pool_avail - pool_open + ns_open[i_alloc_ns];
    al_grant = (i_alloc_count < al_room) ? i_alloc_count : al_room;
    al_sts   = srm_pkg::SRM_OK;
    if (!is_shared(alloc_q[i_alloc_ns])) begin
      al_sts   = srm_pkg::SRM_INVALID_FIELD;
      al_grant = '0;
    end else if (al_room == '0 && pool_avail == '0) begin
      al_sts = srm_pkg::SRM_ALLOC_FAILED;
    end
  end

  // ***************************************************************
  // stream table
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ent_vld_q <= '0;
      for (int e = 0; e < MAX_STREAMS; e++) begin
        ent_ns_q[e]    <= '0;
        ent_sid_q[e]   <= '0;
        ent_stamp_q[e] <= '0;
      end
    end else begin
      for (int e = 0; e < MAX_STREAMS; e++) begin
        if (cmd_fmt && i_format_ns_mask[ent_ns_q[e]]) begin
          ent_vld_q[e] <= 1'b0;
        end
        if (cmd_dis && ent_ns_q[e] == i_disable_ns) begin
          ent_vld_q[e] <= 1'b0;
        end
        if (cmd_rel && ent_ns_q[e] == i_relres_ns) begin
          ent_vld_q[e] <= 1'b0;
        end
        // shared streams of a namespace go when it gets its own
        if (cmd_alloc && al_sts == srm_pkg::SRM_OK && al_grant != '0
            && ent_ns_q[e] == i_alloc_ns) begin
          ent_vld_q[e] <= 1'b0;
        end
      end
      if (cmd_wr && wr_use) begin
        ent_vld_q[wr_slot]   <= 1'b1;
        ent_ns_q[wr_slot]    <= i_wr_ns;
        ent_sid_q[wr_slot]   <= i_wr_sid;
        ent_stamp_q[wr_slot] <= stamp_q;
      end
    end
  end

  // write recency stamp
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stamp_q <= '0;
    end else if (cmd_wr && wr_use) begin
      stamp_q <= stamp_q + 1'b1;
    end
  end

  // ***************************************************************
  // exclusive allocations
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int n = 0; n < NS_NUM; n++) begin
        alloc_q[n] <= '0;
      end
    end else if (cmd_dis) begin
      alloc_q[i_disable_ns] <= '0;
    end else if (cmd_rel) begin
      alloc_q[i_relres_ns] <= '0;
    end else if (cmd_alloc && al_sts == srm_pkg::SRM_OK) begin
      alloc_q[i_alloc_ns] <= al_grant;
    end
  end

  // ***************************************************************
  // answers
  // ***************************************************************
  // write answer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wr_done     <= 1'b0;
      o_wr_streamed <= 1'b0;
      o_wr_evicted  <= 1'b0;
      o_wr_slot     <= '0;
    end else begin
      o_wr_done     <= cmd_wr;
      o_wr_streamed <= cmd_wr & wr_use;
      o_wr_evicted  <= cmd_wr & wr_use & wr_evict;
      o_wr_slot     <= wr_slot;
    end
  end

  // allocation answer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alloc_done    <= 1'b0;
      o_alloc_status  <= srm_pkg::SRM_OK;
      o_alloc_granted <= '0;
    end else begin
      o_alloc_done    <= cmd_alloc;
      o_alloc_status  <= al_sts;
      o_alloc_granted <= al_grant;
    end
  end

  // parameter report; the directive specific field is never looked at
  logic rpt_bcast, rpt_ns_ok;
  assign rpt_bcast = i_rpt_namespace_identifier == `SRM_NAMESPACE_IDENTIFIER_BROADCAST;
  assign rpt_ns_ok = i_rpt_namespace_identifier < 32'(NS_NUM);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rpt_done                 <= 1'b0;
      o_rpt_status               <= srm_pkg::SRM_OK;
      o_rpt_subsys               <= '0;
      o_rpt_ns_streams_allocated <= '0;
      o_rpt_ns_open              <= '0;
    end else begin
      o_rpt_done   <= cmd_rpt;
      o_rpt_status <= (i_rpt_op == `SRM_OP_RETURN_PARAMS && (rpt_bcast || rpt_ns_ok))
                      ? srm_pkg::SRM_OK : srm_pkg::SRM_INVALID_FIELD;
      o_rpt_subsys <= '0;
      o_rpt_subsys[`SRM_RPT_MAX_LSB +: `SRM_CNT_W]   <= 16'(MAX_STREAMS);
      o_rpt_subsys[`SRM_RPT_AVAIL_LSB +: `SRM_CNT_W] <= pool_avail;
      o_rpt_subsys[`SRM_RPT_OPEN_LSB +: `SRM_CNT_W]  <= pool_open;
      if (rpt_ns_ok) begin
        o_rpt_ns_streams_allocated <= alloc_q[NSW'(i_rpt_namespace_identifier)];
        o_rpt_ns_open              <= ns_open[NSW'(i_rpt_namespace_identifier)];
      end else begin
        o_rpt_ns_streams_allocated <= '0;
        o_rpt_ns_open              <= '0;
      end
    end
  end

endmodule
`default_nettype wire

// File: srm_chk.sv
/*
  Checker for the stream manager: answer timing and report field relations.
  Assumes it is bound onto srm_stream_manager and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module srm_chk #(
  parameter int unsigned MAX_STREAMS = 8
) (
  // clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_resetn,
  // command strobes and fields
  input wire logic                 i_wr_valid,
  input wire logic                 i_alloc_valid,
  input wire logic                 i_relres_valid,
  input wire logic                 i_disable_valid,
  input wire logic                 i_format_valid,
  input wire logic                 i_rpt_valid,
  input wire logic [7:0]           i_rpt_op,
  input wire logic [31:0]          i_rpt_namespace_identifier,
  // answers
  input wire logic                 o_wr_done,
  input wire logic                 o_wr_streamed,
  input wire logic                 o_wr_evicted,
  input wire logic                 o_alloc_done,
  input wire srm_pkg::srm_status_t o_alloc_status,
  input wire srm_pkg::srm_cnt_t    o_alloc_granted,
  input wire logic                 o_rpt_done,
  input wire srm_pkg::srm_status_t o_rpt_status,
  input wire logic [127:0]         o_rpt_subsys,
  input wire srm_pkg::srm_cnt_t    o_rpt_ns_streams_allocated,
  input wire srm_pkg::srm_cnt_t    o_rpt_ns_open
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // a strobe is taken only when no higher-priority strobe is up
  wire logic hi    = i_format_valid | i_disable_valid | i_relres_valid;
  wire logic tk_al = i_alloc_valid & !hi;
  wire logic tk_wr = i_wr_valid & !hi & !i_alloc_valid;
  wire logic tk_rp = i_rpt_valid & !hi & !i_alloc_valid & !i_wr_valid;
  a_wr_done_lat: assert property (tk_wr |=> o_wr_done)
    else $error("write not answered next cycle");
  a_wr_done_src: assert property (o_wr_done |-> $past(tk_wr))
    else $error("write answer without a taken write");
  a_evict_streamed: assert property (o_wr_done && o_wr_evicted |-> o_wr_streamed)
    else $error("eviction on a plain write");
  a_alloc_done_lat: assert property (tk_al |=> o_alloc_done)
    else $error("allocation not answered next cycle");
  a_alloc_err_zero: assert property (o_alloc_done && o_alloc_status != srm_pkg::SRM_OK
    |-> o_alloc_granted == '0)
    else $error("grant reported with an error status");
  a_rpt_done_lat: assert property (tk_rp |=> o_rpt_done)
    else $error("report not answered next cycle");
  a_rpt_bad_op: assert property (tk_rp && i_rpt_op != 8'h01
    |=> o_rpt_status == srm_pkg::SRM_INVALID_FIELD)
    else $error("unknown report operation accepted");
  a_rpt_bcast_zero: assert property (tk_rp && i_rpt_op == 8'h01
    && i_rpt_namespace_identifier == 32'hffffffff |=> o_rpt_status == srm_pkg::SRM_OK
    && o_rpt_ns_streams_allocated == '0 && o_rpt_ns_open == '0)
    else $error("broadcast report carries namespace values");
  a_rpt_fixed_fld: assert property (o_rpt_done |-> o_rpt_subsys[127:48] == '0
    && o_rpt_subsys[15:0] == MAX_STREAMS)
    else $error("reserved bytes or maximum wrong");
  a_pool_bound: assert property (o_rpt_done |-> o_rpt_subsys[31:16] <= MAX_STREAMS
    && o_rpt_subsys[47:32] <= o_rpt_subsys[31:16])
    else $error("shared pool counts out of range");
  // main scenarios
  c_evict: cover property (o_wr_done && o_wr_evicted);
  c_fail: cover property (o_alloc_done && o_alloc_status == srm_pkg::SRM_ALLOC_FAILED);
  c_pool_empty: cover property (o_rpt_done && o_rpt_subsys[31:16] == '0);
endmodule
bind srm_stream_manager srm_chk #(.MAX_STREAMS(MAX_STREAMS)) u_chk (
  .i_clk, .i_resetn, .i_wr_valid, .i_alloc_valid, .i_relres_valid, .i_disable_valid,
  .i_format_valid, .i_rpt_valid, .i_rpt_op, .i_rpt_namespace_identifier, .o_wr_done,
  .o_wr_streamed, .o_wr_evicted, .o_alloc_done, .o_alloc_status, .o_alloc_granted,
  .o_rpt_done, .o_rpt_status, .o_rpt_subsys, .o_rpt_ns_streams_allocated, .o_rpt_ns_open
);
`default_nettype wire

// File: srm_host_model.sv
/*
  Host model: issues one command per call, fields set at the falling edge.
  Assumes four namespaces; strobes stand for exactly one rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module srm_host_model (
  // clock
  input  wire logic   i_clk,
  // strobes
  output logic        o_wr_valid,
  output logic        o_alloc_valid,
  output logic        o_relres_valid,
  output logic        o_disable_valid,
  output logic        o_format_valid,
  output logic        o_rpt_valid,
  // fields shared by all commands
  output logic [1:0]  o_ns,
  output logic [15:0] o_val,
  output logic [3:0]  o_mask,
  output logic [7:0]  o_op,
  output logic [31:0] o_namespace_identifier,
  output logic [15:0] o_directive_specific_field
);
  // ************************************************************
  // command issue
  // ************************************************************
  initial begin
    {o_wr_valid, o_alloc_valid, o_relres_valid, o_disable_valid} = '0;
    {o_format_valid, o_rpt_valid, o_ns, o_val, o_mask, o_op, o_namespace_identifier, o_directive_specific_field} = '0;
  end
  // k selects the command; releases are how the host keeps its own limits
  task automatic send(input int k, input int n, input logic [15:0] v,
                      input logic [31:0] id, input logic [15:0] d);
    @(negedge i_clk);
    {o_wr_valid, o_alloc_valid, o_relres_valid} = {k == 0, k == 1, k == 2};
    {o_disable_valid, o_format_valid, o_rpt_valid} = {k == 3, k == 4, k == 5};
    o_ns = n[1:0];
    o_val = v;
    o_mask = v[3:0];
    o_op = v[7:0];
    o_namespace_identifier = id;
    o_directive_specific_field = d;
    @(negedge i_clk);
    {o_wr_valid, o_alloc_valid, o_relres_valid} = '0;
    {o_disable_valid, o_format_valid, o_rpt_valid} = '0;
    // stale value and namespace identifier are scrambled so nothing leans on them
    o_val = ~v;
    o_namespace_identifier = ~id;
  endtask
endmodule
`default_nettype wire

// File: test_stream_resource_manager.sv
/*
  Testbench: reference model of stream table and pool, compared at each answer.
  Assumes default sizes: eight streams, four namespaces.
*/
`timescale 1ns/1ps
`default_nettype none
module test_stream_resource_manager;
  // ************************************************************
  // wiring
  // ************************************************************
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wr_valid, i_alloc_valid, i_relres_valid, i_disable_valid, i_format_valid;
  logic i_rpt_valid, o_wr_done, o_wr_streamed, o_wr_evicted, o_alloc_done, o_rpt_done;
  logic [1:0] h_ns;
  logic [15:0] h_val;
  logic [3:0] i_format_ns_mask;
  logic [7:0] i_rpt_op;
  logic [31:0] i_rpt_namespace_identifier;
  logic [15:0] i_rpt_directive_specific_field;
  logic [2:0] o_wr_slot;
  logic [127:0] o_rpt_subsys;
  srm_pkg::srm_status_t o_alloc_status, o_rpt_status;
  srm_pkg::srm_cnt_t o_alloc_granted, o_rpt_ns_streams_allocated, o_rpt_ns_open;
  wire logic [1:0] i_wr_ns = h_ns;
  wire logic [1:0] i_alloc_ns = h_ns;
  wire logic [1:0] i_relres_ns = h_ns;
  wire logic [1:0] i_disable_ns = h_ns;
  wire srm_pkg::srm_sid_t i_wr_sid = h_val;
  wire srm_pkg::srm_cnt_t i_alloc_count = h_val;
  int n_errors = 0;
  int checks = 0;
  int av = 8;
  int al[4] = '{0, 0, 0, 0};
  int qn[$];
  int qs[$];
  int qp[$];
  int vs;
  logic [15:0] lf = 16'hec08;
  always #10 i_clk = ~i_clk;
  srm_stream_manager DUT (
    .i_clk, .i_resetn, .i_wr_valid, .i_wr_ns, .i_wr_sid, .o_wr_done, .o_wr_streamed,
    .o_wr_evicted, .o_wr_slot, .i_alloc_valid, .i_alloc_ns, .i_alloc_count, .o_alloc_done,
    .o_alloc_status, .o_alloc_granted, .i_relres_valid, .i_relres_ns, .i_disable_valid,
    .i_disable_ns, .i_format_valid, .i_format_ns_mask, .i_rpt_valid, .i_rpt_op,
    .i_rpt_namespace_identifier, .i_rpt_directive_specific_field, .o_rpt_done, .o_rpt_status,
    .o_rpt_subsys, .o_rpt_ns_streams_allocated, .o_rpt_ns_open
  );
  srm_host_model h (
    .i_clk          (i_clk),
    .o_wr_valid     (i_wr_valid),
    .o_alloc_valid  (i_alloc_valid),
    .o_relres_valid (i_relres_valid),
    .o_disable_valid(i_disable_valid),
    .o_format_valid (i_format_valid),
    .o_rpt_valid    (i_rpt_valid),
    .o_ns           (h_ns),
    .o_val          (h_val),
    .o_mask         (i_format_ns_mask),
    .o_op           (i_rpt_op),
    .o_namespace_identifier         (i_rpt_namespace_identifier),
    .o_directive_specific_field        (i_rpt_directive_specific_field)
  );
  // ************************************************************
  // model and checks
  // ************************************************************
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // sh counts shared-pool streams, else streams of namespace n
  function automatic int cnt(input int n, input bit sh);
    int c = 0;
    foreach (qn[i]) if (sh ? al[qn[i]] == 0 : qn[i] == n) c++;
    return c;
  endfunction
  // queue front is the least recently written stream
  function automatic void evict(input int n, input bit sh);
    foreach (qn[i]) if (sh ? al[qn[i]] == 0 : qn[i] == n) begin
      vs = qp[i];
      qn.delete(i);
      qs.delete(i);
      qp.delete(i);
      return;
    end
  endfunction
  function automatic void drop(input int n);
    for (int i = qn.size() - 1; i >= 0; i--) if (qn[i] == n) begin
      qn.delete(i);
      qs.delete(i);
      qp.delete(i);
    end
  endfunction
  // lowest free slot, the one the table fills first
  function automatic int lo();
    for (int p = 0; p < 8; p++) begin
      int u = 0;
      foreach (qp[i]) if (qp[i] == p) u = 1;
      if (!u) return p;
    end
    return 0;
  endfunction
  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic wr(input int n, input logic [15:0] s);
    int st = 1;
    int ev = 0;
    int f = -1;
    int p = -1;
    h.send(0, n, s, 0, 0);
    foreach (qs[i]) if (qs[i] == s && qn[i] == n) f = i;
    if (s == 0) st = 0;
    else if (f >= 0) begin
      p = qp[f];
      qn.delete(f);
      qs.delete(f);
      qp.delete(f);
    end else if (al[n] > 0) begin
      if (cnt(n, 0) >= al[n]) begin
        evict(n, 0);
        ev = 1;
      end
    end else if (av == 0) st = 0;
    else if (cnt(0, 1) >= av) begin
      evict(0, 1);
      ev = 1;
    end
    if (ev) p = vs;
    if (st) begin
      if (p < 0) p = lo();
      qn.push_back(n);
      qs.push_back(s);
      qp.push_back(p);
      chk(o_wr_slot, p);
    end
    chk(o_wr_done, 1);
    chk(o_wr_streamed, st);
    chk(o_wr_evicted, ev);
  endtask
  task automatic alc(input int n, input int r);
    int rm = av - cnt(0, 1) + cnt(n, 0);
    int g = (r < rm) ? r : rm;
    logic [7:0] e = 8'h00;
    h.send(1, n, r[15:0], 0, 0);
    if (al[n] != 0) begin
      e = 8'h02;
      g = 0;
    end else if (g <= 0) begin
      e = (av == 0) ? 8'h7f : 8'h00;
      g = 0;
    end else begin
      al[n] = g;
      av -= g;
      drop(n);
    end
    chk(o_alloc_done, 1);
    chk(o_alloc_status, e);
    chk(o_alloc_granted, g);
  endtask
  task automatic rel(input int k, input int n);
    h.send(k, n, 0, 0, 0);
    av += al[n];
    al[n] = 0;
    drop(n);
  endtask
  task automatic rp(input logic [7:0] op, input logic [31:0] id);
    bit ok = op == 8'h01 && (id < 4 || id == 32'hffffffff);
    lf = nx(lf);
    h.send(5, 0, {8'h00, op}, id, lf);
    chk(o_rpt_done, 1);
    chk(o_rpt_status, ok ? 8'h00 : 8'h02);
    if (ok) begin
      chk(o_rpt_subsys, {80'h0, 16'(cnt(0, 1)), 16'(av), 16'h0008});
      chk(o_rpt_ns_streams_allocated, (id < 4) ? al[id[1:0]] : 0);
      chk(o_rpt_ns_open, (id < 4) ? cnt(id[1:0], 0) : 0);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    logic [15:0] s[8];
    repeat (12) @(posedge i_clk);
    @(negedge i_clk) i_resetn = 1'b1;
    rp(8'h01, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      s[i] = lf;
      wr(0, s[i]);
    end
    wr(0, s[0]);
    lf = nx(lf);
    wr(1, lf);
    wr(0, s[1]);
    alc(2, 3);
    rp(8'h01, 32'h1);
    rel(3, 0);
    alc(1, 3);
    alc(1, 2);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      wr(1, lf);
    end
    rp(8'h01, 32'h1);
    alc(2, 9);
    lf = nx(lf);
    wr(0, lf);
    alc(3, 1);
    wr(2, 16'h0001);
    wr(2, 16'hffff);
    wr(2, 16'h0000);
    h.send(4, 0, 16'h0004, 0, 0);
    drop(2);
    rp(8'h01, 32'h2);
    rp(8'h01, 32'h7);
    rp(8'h02, 32'h1);
    rel(2, 1);
    alc(1, 1);
    rp(8'h01, 32'hffffffff);
    wrap_up;
  end
  // cuts a hang short after about 2000 cycles
  initial begin
    #40000;
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
